// >>> core/ascii_cmd_consts.svh
// Constants for the serial ASCII command parser.
// Assumes a single 200 MHz clock domain and an 8N1 serial link.
// Summary of operation
// [R1] Link runs 9600 baud, 8N1, both directions
// [R2] Every received character is echoed back
// [R3] Carriage return ends string, echoed as space
// [R4] Eighty characters buffered, then execution starts anyway
// [R5] Leading question mark marks an inquiry word
// [R6] Volatile-set prefix marks a volatile setting
// [R7] Non-volatile-set prefix marks a stored setting
// [R8] Other words are plain commands, no parameter; code classes words led by a digit, minus or dot as CLS_PARAM
// [R9] Good inquiry: data, space, ok, CR LF
// [R10] Bad inquiry: word, space, hash-question, CR LF
// [R11] Words concatenated, separated by one or more spaces
// [R12] Good string: inquiry data in order, one ok
// [R13] On failure report first bad word, discard rest
// [R14] Host paces characters at least 50 ms apart
// [R15] Host may instead wait for each echo
// [R16] Inquiries begin with question mark, end CR
// [R17] No hardware handshake lines used
// [R18] Buffer cleared after string executed and answered
`ifndef ASCII_CMD_CONSTS_SVH
`define ASCII_CMD_CONSTS_SVH

`define CLK_FREQ_HZ 200000000
`define BAUD_RATE 9600
`define BUF_DEPTH 80
`define HOST_CHAR_GAP_MS 50

`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_SPACE 8'h20
`define CH_QUEST 8'h3F
`define CH_HASH 8'h23
`define CH_LOW_O 8'h6F
`define CH_LOW_K 8'h6B
`define CH_MINUS 8'h2D
`define CH_DOT 8'h2E
`define CH_DIGIT0 8'h30
`define CH_DIGIT9 8'h39
`define CH_UP_P 8'h50
`define CH_UP_U 8'h55
`define CH_UP_T 8'h54
`define CH_UP_I 8'h49
`define CH_UP_N 8'h4E
`define TAIL_LAST 3'h4

`endif

// >>> core/ascii_cmd_pkg.sv
// Types for the serial ASCII command parser.
// Assumes ascii_cmd_consts.svh supplies the numeric constants.
package ascii_cmd_pkg;
  typedef enum logic [2:0] {
    CLS_INQUIRY,
    CLS_VOL_SET,
    CLS_NV_SET,
    CLS_PARAM,
    CLS_PLAIN
  } word_class_t;

  typedef enum {
    S_COLLECT,
    S_SKIP,
    S_SCAN,
    S_EXEC,
    S_ERR_WORD,
    S_TAIL,
    S_DONE
  } parse_state_t;
endpackage

// >>> core/ascii_cmd_parser.sv
// Serial ASCII command parser: UART, echo, 80-char buffer, word splitter.
// Assumes an executor on the user side judges each word and supplies
// inquiry data; rxd comes from a pin, everything else from clk logic.
`timescale 1ns/1ps
`include "ascii_cmd_consts.svh"

module ascii_cmd_parser
  import ascii_cmd_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = `CLK_FREQ_HZ / `BAUD_RATE,
  parameter int unsigned DEPTH = `BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  // Word presented to the executor
  output logic word_valid,
  output word_class_t word_class,
  output logic [6:0] word_len,
  input wire logic [6:0] word_char_idx,
  output logic [7:0] word_char,
  input wire logic word_done,
  input wire logic word_ok,
  // Inquiry reply data from the executor
  input wire logic resp_valid,
  input wire logic [7:0] resp_char,
  output logic resp_ready,
  // End of string
  output logic str_commit,
  output logic str_discard
);

  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;

  function automatic logic [7:0] tail_char(input logic err, input logic [2:0] idx);
    logic [7:0] c;
    c = `CH_SPACE;
    unique case (idx)
      3'h0: c = `CH_SPACE;
      3'h1: c = err ? `CH_HASH : `CH_LOW_O;
      3'h2: c = err ? `CH_QUEST : `CH_LOW_K;
      3'h3: c = `CH_CR;
      default: c = `CH_LF;
    endcase
    return c;
  endfunction

  logic [7:0] buf_q [DEPTH];

  function automatic logic [7:0] buf_at(input logic [7:0] i);
    logic [7:0] c;
    c = 8'h00;
    if (32'(i) < DEPTH)
    begin
      c = buf_q[i[6:0]];
    end
    return c;
  endfunction

  // Receiver, pin synchronised first
  logic rx_meta_q, rx_sync_q;
  logic rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_valid_q;
  logic [7:0] rx_byte_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else
    begin
      rx_meta_q <= rxd;
      rx_sync_q <= rx_meta_q;
    end
  end

  // [R1] 8N1 receive framing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (!rx_sync_q)
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= 16'(HALF_CYCLES);
          rx_bit_q <= 4'h0;
        end
      end
      else if (rx_cnt_q != 16'h0000)
      begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
      else
      begin
        rx_cnt_q <= 16'(BIT_CYCLES - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0)
        begin
          rx_busy_q <= ~rx_sync_q;
        end
        else if (rx_bit_q == 4'h9)
        begin
          rx_busy_q <= 1'b0;
          rx_valid_q <= rx_sync_q;
          rx_byte_q <= rx_shift_q;
        end
        else
        begin
          rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
        end
      end
    end
  end

  // Transmitter; echo wins over reply
  logic echo_pend_q;
  logic [7:0] echo_byte_q;
  logic reply_valid_q;
  logic [7:0] reply_byte_q;
  logic tx_busy_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_shift_q;
  logic tx_take_echo, tx_take_reply;

  // [R17] Start without waiting on any handshake
  assign tx_take_echo = !tx_busy_q && echo_pend_q;
  assign tx_take_reply = !tx_busy_q && !echo_pend_q && reply_valid_q;

  // [R2] Echo every received character
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      echo_pend_q <= 1'b0;
      echo_byte_q <= 8'h00;
    end
    else if (rx_valid_q)
    begin
      echo_pend_q <= 1'b1;
      // [R3] Carriage return echoed as space
      echo_byte_q <= (rx_byte_q == `CH_CR) ? `CH_SPACE : rx_byte_q;
    end
    else if (tx_take_echo)
    begin
      echo_pend_q <= 1'b0;
    end
  end

  // [R1] 8N1 transmit framing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 10'h3FF;
    end
    else if (!tx_busy_q)
    begin
      if (tx_take_echo || tx_take_reply)
      begin
        tx_busy_q <= 1'b1;
        tx_cnt_q <= 16'(BIT_CYCLES - 1);
        tx_bit_q <= 4'h0;
        tx_shift_q <= {1'b1, tx_take_echo ? echo_byte_q : reply_byte_q, 1'b0};
      end
    end
    else if (tx_cnt_q != 16'h0000)
    begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
    else
    begin
      tx_cnt_q <= 16'(BIT_CYCLES - 1);
      tx_shift_q <= {1'b1, tx_shift_q[9:1]};
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_busy_q <= (tx_bit_q != 4'h9);
    end
  end

  assign txd = tx_shift_q[0];

  // Parser
  parse_state_t state_q;
  logic [6:0] cnt_q, ptr_q, ws_q, eptr_q;
  logic [2:0] tidx_q;
  logic err_q;
  logic slot_free;
  logic [7:0] cur_char;

  assign slot_free = !reply_valid_q || tx_take_reply;
  assign resp_ready = (state_q == S_EXEC) && slot_free;

  always_ff @(posedge clk)
  begin
    if (state_q == S_COLLECT && rx_valid_q && rx_byte_q != `CH_CR)
    begin
      buf_q[cnt_q] <= rx_byte_q;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_COLLECT;
      cnt_q <= 7'h00;
      ptr_q <= 7'h00;
      ws_q <= 7'h00;
      eptr_q <= 7'h00;
      tidx_q <= 3'h0;
      err_q <= 1'b0;
      str_commit <= 1'b0;
      str_discard <= 1'b0;
    end
    else
    begin
      str_commit <= 1'b0;
      str_discard <= 1'b0;
      unique case (state_q)
        S_COLLECT:
        begin
          ptr_q <= 7'h00;
          err_q <= 1'b0;
          tidx_q <= 3'h0;
          if (rx_valid_q)
          begin
            // [R3] Carriage return starts execution
            if (rx_byte_q == `CH_CR)
            begin
              state_q <= S_SKIP;
            end
            else
            begin
              cnt_q <= cnt_q + 7'h01;
              // [R4] Full buffer starts execution
              if (32'(cnt_q) + 1 == DEPTH)
              begin
                state_q <= S_SKIP;
              end
            end
          end
        end
        // [R11] Any run of spaces separates words
        S_SKIP:
        begin
          if (ptr_q == cnt_q)
          begin
            state_q <= S_TAIL;
          end
          else if (cur_char == `CH_SPACE)
          begin
            ptr_q <= ptr_q + 7'h01;
          end
          else
          begin
            ws_q <= ptr_q;
            state_q <= S_SCAN;
          end
        end
        S_SCAN:
        begin
          if (ptr_q != cnt_q && cur_char != `CH_SPACE)
          begin
            ptr_q <= ptr_q + 7'h01;
          end
          else
          begin
            state_q <= S_EXEC;
          end
        end
        S_EXEC:
        begin
          if (word_done)
          begin
            eptr_q <= ws_q;
            // [R13] First failure stops the string
            state_q <= word_ok ? S_SKIP : S_ERR_WORD;
            err_q <= !word_ok;
          end
        end
        // [R10] Echo the failing word back
        S_ERR_WORD:
        begin
          if (slot_free)
          begin
            if (eptr_q == ptr_q)
            begin
              state_q <= S_TAIL;
            end
            else
            begin
              eptr_q <= eptr_q + 7'h01;
            end
          end
        end
        // [R9] Single closing token after all data
        S_TAIL:
        begin
          if (slot_free)
          begin
            tidx_q <= tidx_q + 3'h1;
            if (tidx_q == `TAIL_LAST)
            begin
              state_q <= S_DONE;
            end
          end
        end
        // [R18] Clear buffer once the last reply byte is taken by the transmitter
        S_DONE:
        begin
          if (!reply_valid_q)
          begin
            cnt_q <= 7'h00;
            str_commit <= !err_q;
            str_discard <= err_q;
            state_q <= S_COLLECT;
          end
        end
      endcase
    end
  end

  // Reply slot feeding the transmitter
  // [R12] Inquiry data passes in issue order
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reply_valid_q <= 1'b0;
      reply_byte_q <= 8'h00;
    end
    else
    begin
      if (tx_take_reply)
      begin
        reply_valid_q <= 1'b0;
      end
      if (resp_ready && resp_valid)
      begin
        reply_valid_q <= 1'b1;
        reply_byte_q <= resp_char;
      end
      else if (state_q == S_ERR_WORD && slot_free && eptr_q != ptr_q)
      begin
        reply_valid_q <= 1'b1;
        reply_byte_q <= buf_q[eptr_q];
      end
      else if (state_q == S_TAIL && slot_free)
      begin
        reply_valid_q <= 1'b1;
        reply_byte_q <= tail_char(err_q, tidx_q);
      end
    end
  end

  // Word classification and character access
  logic [7:0] c0, c1, c2, c3, c4;

  // Buffer reads in a process, so fresh buffer writes are seen
  always_comb
  begin
    cur_char = buf_at({1'b0, ptr_q});
    c0 = buf_at({1'b0, ws_q});
    c1 = buf_at({1'b0, ws_q} + 8'h01);
    c2 = buf_at({1'b0, ws_q} + 8'h02);
    c3 = buf_at({1'b0, ws_q} + 8'h03);
    c4 = buf_at({1'b0, ws_q} + 8'h04);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      word_valid <= 1'b0;
      word_class <= CLS_PLAIN;
      word_len <= 7'h00;
      word_char <= 8'h00;
    end
    else
    begin
      word_valid <= (state_q == S_SCAN && (ptr_q == cnt_q || cur_char == `CH_SPACE))
                    || (state_q == S_EXEC && !word_done);
      word_len <= ptr_q - ws_q;
      word_char <= buf_at({1'b0, ws_q} + {1'b0, word_char_idx});
      // [R16] Question mark always leads an inquiry
      // [R5] Inquiry class
      if (c0 == `CH_QUEST)
      begin
        word_class <= CLS_INQUIRY;
      end
      // [R6] Volatile-set class
      else if (ptr_q - ws_q >= 7'h03 && c0 == `CH_UP_P && c1 == `CH_UP_U
               && c2 == `CH_UP_T)
      begin
        word_class <= CLS_VOL_SET;
      end
      // [R7] Non-volatile-set class
      else if (ptr_q - ws_q >= 7'h05 && c0 == `CH_UP_I && c1 == `CH_UP_N
               && c2 == `CH_UP_I && c3 == `CH_UP_T && c4 == `CH_MINUS)
      begin
        word_class <= CLS_NV_SET;
      end
      else if ((c0 >= `CH_DIGIT0 && c0 <= `CH_DIGIT9) || c0 == `CH_MINUS
               || c0 == `CH_DOT)
      begin
        word_class <= CLS_PARAM;
      end
      // [R8] Plain command class
      else
      begin
        word_class <= CLS_PLAIN;
      end
    end
  end

endmodule // ascii_cmd_parser

// >>> sim/host_uart.sv
// Host terminal model: frames bytes onto rxd, gathers bytes from txd.
// Assumes 8N1 framing at BC clocks per bit and a quiet idle-high line.
`timescale 1ns/1ps
module host_uart #(
  parameter int BC = 16
) (
  // Clock
  input wire logic clk,
  // Serial pins, no handshake lines
  input wire logic txd,
  output logic rxd
);
  string got = "";
  logic [7:0] b;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk) #1 rxd = f[i];
      repeat (BC - 1) @(posedge clk);
    end
  endtask
  initial forever
  begin
    @(negedge txd);
    repeat (BC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BC) @(posedge clk);
      b[i] = txd;
    end
    repeat (BC) @(posedge clk);
    got = $sformatf("%s%c", got, b);
  end
endmodule // host_uart

// >>> sim/ascii_cmd_parser_props.sv
// Port checks for the ASCII command parser.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module ascii_cmd_parser_props
  import ascii_cmd_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 16,
  parameter int unsigned DEPTH = 80
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic rxd,
  input wire logic txd,
  // Word side
  input wire logic word_valid,
  input wire word_class_t word_class,
  input wire logic [6:0] word_len,
  input wire logic [6:0] word_char_idx,
  input wire logic [7:0] word_char,
  input wire logic word_done,
  input wire logic word_ok,
  // Reply side and string end
  input wire logic resp_valid,
  input wire logic [7:0] resp_char,
  input wire logic resp_ready,
  input wire logic str_commit,
  input wire logic str_discard
);
  logic txd_q;
  logic [15:0] run_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst)
    if (rst)
      txd_q <= 1'b1;
    else
      txd_q <= txd;
  // Cycles the line has held its level
  always_ff @(posedge clk or posedge rst)
    if (rst)
      run_q <= 16'h0000;
    else if (txd != txd_q)
      run_q <= 16'h0001;
    else if (run_q != 16'hffff)
      run_q <= run_q + 16'h0001;
  a_bit_width: assert property (txd != txd_q |-> run_q >= BIT_CYCLES)
    else $error("txd level shorter than one bit");
  a_reset_idle: assert property ($fell(rst) |-> txd && !word_valid && !str_commit)
    else $error("outputs not idle after reset");
  a_word_hold: assert property (word_valid && !word_done |=>
    word_valid && $stable(word_class) && $stable(word_len))
    else $error("word changed before done");
  a_word_drop: assert property (word_valid && word_done |=> !word_valid)
    else $error("word kept after done");
  a_len_range: assert property (word_valid |-> word_len != 7'h00 && word_len <= DEPTH)
    else $error("word length out of range");
  a_commit_pulse: assert property (str_commit |=> !str_commit)
    else $error("commit longer than one cycle");
  a_discard_pulse: assert property (str_discard |=> !str_discard)
    else $error("discard longer than one cycle");
  a_end_excl: assert property (str_commit || str_discard |->
    !(str_commit && str_discard) && !word_valid)
    else $error("string end overlaps word");
  a_fail_skip: assert property (word_valid && word_done && !word_ok |=>
    (!word_valid) [*8])
    else $error("word shown after failure");
  c_inquiry: cover property (word_valid && word_class == CLS_INQUIRY);
  c_commit: cover property (str_commit);
  c_discard: cover property (str_discard);
endmodule // ascii_cmd_parser_props
bind ascii_cmd_parser ascii_cmd_parser_props #(
  .BIT_CYCLES(BIT_CYCLES),
  .DEPTH(DEPTH)
) props_u (
  .clk(clk),
  .rst(rst),
  .rxd(rxd),
  .txd(txd),
  .word_valid(word_valid),
  .word_class(word_class),
  .word_len(word_len),
  .word_char_idx(word_char_idx),
  .word_char(word_char),
  .word_done(word_done),
  .word_ok(word_ok),
  .resp_valid(resp_valid),
  .resp_char(resp_char),
  .resp_ready(resp_ready),
  .str_commit(str_commit),
  .str_discard(str_discard)
);

// >>> sim/test_serial_ascii_command_parser.sv
// Bench for the ASCII command parser with a host model and an executor.
// Assumes the parser, its package and the host model are compiled first.
`timescale 1ns/1ps
module test_serial_ascii_command_parser
  import ascii_cmd_pkg::*;
;
  localparam int BC = 16;
  localparam string CR = "\015";
  localparam string NL = "\015\012";
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rxd;
  logic txd;
  logic word_valid;
  word_class_t word_class;
  logic [6:0] word_len;
  logic [7:0] word_char;
  logic word_done = 1'b0;
  logic word_ok = 1'b0;
  logic resp_valid = 1'b0;
  logic resp_ready;
  logic [6:0] char_idx = 7'h00;
  logic [7:0] rdata = 8'h00;
  logic [7:0] fc;
  bit paced = 1'b0;
  logic str_commit;
  logic str_discard;
  int bad_len = 0;
  int n_com = 0;
  int n_dis = 0;
  int n_fail = 0;
  int samples_checked = 0;
  string cls_s = "";
  ascii_cmd_parser #(.BIT_CYCLES(BC), .DEPTH(80)) dut_u (
    .clk(clk),
    .rst(rst),
    .rxd(rxd),
    .txd(txd),
    .word_valid(word_valid),
    .word_class(word_class),
    .word_len(word_len),
    .word_char_idx(char_idx),
    .word_char(word_char),
    .word_done(word_done),
    .word_ok(word_ok),
    .resp_valid(resp_valid),
    .resp_char(rdata),
    .resp_ready(resp_ready),
    .str_commit(str_commit),
    .str_discard(str_discard)
  );
  host_uart #(.BC(BC)) host_u (.clk(clk), .txd(txd), .rxd(rxd));
  initial forever #2.5 clk = ~clk;
  function automatic string w(word_class_t c, int n, string s);
    return $sformatf("%0d:%0d%s,", c, n, s);
  endfunction
  // Executor: reads first and last character, sends the last for a good inquiry
  initial forever
  begin
    @(posedge clk) #1;
    if (word_valid === 1'b1)
    begin
      fc = word_char;
      char_idx = word_len - 7'h01;
      @(posedge clk) #1;
      cls_s = {cls_s, w(word_class, word_len, $sformatf("%c%c", fc, word_char))};
      char_idx = 7'h00;
      if (word_len != bad_len && word_class == CLS_INQUIRY)
      begin
        rdata = word_char;
        resp_valid = 1'b1;
        while (resp_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1 resp_valid = 1'b0;
      end
      word_ok = (word_len != bad_len);
      word_done = 1'b1;
      @(posedge clk) #1 word_done = 1'b0;
    end
  end
  always @(posedge clk)
  begin
    if (str_commit === 1'b1) n_com++;
    if (str_discard === 1'b1) n_dis++;
  end
  task automatic chk(string nm, string e, string s);
    samples_checked++;
    if (e != s)
    begin
      n_fail++;
      $display("BAD %s exp=%s seen=%s", nm, e, s);
    end
  endtask
  task automatic say(string s);
    int n;
    for (int i = 0; i < s.len(); i++)
    begin
      n = host_u.got.len();
      host_u.send(s[i]);
      if (paced)
      begin
        // Fixed gap, scaled to the bit time
        repeat (10 * BC) @(posedge clk);
      end
      else
      begin
        for (int k = 0; k < 14 * BC && host_u.got.len() == n; k++) @(posedge clk);
      end
    end
  endtask
  task automatic run(string nm, string s, string e, string c, int nc, int nd);
    host_u.got = "";
    cls_s = "";
    n_com = 0;
    n_dis = 0;
    say(s);
    for (int k = 0; k < 40 * BC * e.len() && host_u.got.len() < e.len(); k++)
      @(posedge clk);
    repeat (24 * BC) @(posedge clk);
    chk({nm, " text"}, e, host_u.got);
    chk({nm, " words"}, c, cls_s);
    chk({nm, " ends"}, $sformatf("%0d%0d", nc, nd), $sformatf("%0d%0d", n_com, n_dis));
  endtask
  task automatic t_inquiry();
    run("inq", {"?A B", CR}, {"?A B A ok", NL},
      {w(CLS_INQUIRY, 2, "?A"), w(CLS_PLAIN, 1, "BB")}, 1, 0);
  endtask
  task automatic t_classes();
    run("mix", {"PUTX  INIT-Y 7 Z", CR}, {"PUTX  INIT-Y 7 Z  ok", NL},
      {w(CLS_VOL_SET, 4, "PX"), w(CLS_NV_SET, 6, "IY"), w(CLS_PARAM, 1, "77"),
       w(CLS_PLAIN, 1, "ZZ")}, 1, 0);
  endtask
  task automatic t_error();
    bad_len = 3;
    run("err", {"?XY ?C", CR}, {"?XY ?C ?XY #?", NL}, w(CLS_INQUIRY, 3, "?Y"), 0, 1);
    bad_len = 0;
  endtask
  task automatic t_full();
    string a;
    a = "";
    repeat (80) a = {a, "A"};
    run("full", a, {a, " ok", NL}, w(CLS_PLAIN, 80, "AA"), 1, 0);
    paced = 1'b1;
    // Fresh string after, paced host, data in order
    run("next", {"?B ?C", CR}, {"?B ?C BC ok", NL},
      {w(CLS_INQUIRY, 2, "?B"), w(CLS_INQUIRY, 2, "?C")}, 1, 0);
    paced = 1'b0;
    run("empty", CR, {"  ok", NL}, "", 1, 0);
  endtask
  task automatic close_out();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_inquiry();
    t_classes();
    t_error();
    t_full();
    close_out();
  end
  initial
  begin
    #450_000;
    n_fail++;
    close_out();
  end
endmodule // test_serial_ascii_command_parser
